//--- logic/adcseq_pkg.sv
// adcseq_pkg: constants and types for the track/hold and conversion sequencer.
// assumes one system clock of 125 MHz and a serial bus clock from the master.
`default_nettype none
package adcseq_pkg;
   localparam int ADCSEQ_BITS = 8;
   localparam logic [3:0] ADCSEQ_TRACK_EDGE_INT = 4'h9; // falling edge that starts tracking
   localparam logic [3:0] ADCSEQ_TRACK_EDGE_EXT = 4'h7;
   localparam logic [3:0] ADCSEQ_HOLD_EDGE_EXT = 4'h8;
   localparam logic [3:0] ADCSEQ_BYTE_EDGES = 4'h9; // eight data bits plus acknowledge
   localparam logic [1:0] ADCSEQ_ACQ_INT = 2'h2; // internal clocks of acquisition
   localparam logic [3:0] ADCSEQ_CONV_STEPS = 4'h8;
   localparam logic [2:0] ADCSEQ_SEL_RESET = 3'h0;
   localparam logic ADCSEQ_CLK_RESET = 1'h0;
   // pin role of the shared input/reference pin
   typedef enum logic [1:0] {
      ADCSEQ_PIN_INPUT,
      ADCSEQ_PIN_REF_IN,
      ADCSEQ_PIN_REF_OUT
   } adcseq_pin_role_t;
   // mux routing handed to the analog front end
   typedef struct packed {
      logic [3:0] pos_sel;
      logic [3:0] neg_sel;
      logic neg_is_gnd;
   } adcseq_mux_t;
endpackage
`default_nettype wire

//--- logic/adcseq_sar.sv
// adcseq_sar: eight-step successive-approximation register.
// assumes the comparator settles between enabled steps.
`default_nettype none
module adcseq_sar
   import adcseq_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // control
   input wire logic start_in,
   input wire logic step_in,
   input wire logic comp_in,
   // results
   output logic [7:0] trial_out,
   output logic [7:0] result_out,
   output logic done_out
);
   logic [7:0] trial_reg, trial_next, mask_reg, mask_next, result_reg, result_next;
   logic done_reg, done_next;
   logic [7:0] kept;
   // trial code with the bit under test kept or dropped by the comparator
   assign kept = comp_in ? trial_reg : (trial_reg & ~mask_reg);
   // one bit decided per step, msb first
   assign trial_next = start_in ? 8'h80 : (step_in ? (kept | (mask_reg >> 1)) : trial_reg);
   assign mask_next = start_in ? 8'h80 : (step_in ? (mask_reg >> 1) : mask_reg);
   assign done_next = step_in && mask_reg == 8'h01;
   assign result_next = done_next ? kept : result_reg;
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         trial_reg <= 8'h00;
         mask_reg <= 8'h00;
         result_reg <= 8'h00;
         done_reg <= 1'b0;
      end else begin
         trial_reg <= trial_next;
         mask_reg <= mask_next;
         result_reg <= result_next;
         done_reg <= done_next;
      end
   end
   assign trial_out = trial_reg;
   assign result_out = result_reg;
   assign done_out = done_reg;
endmodule // adcseq_sar
`default_nettype wire

//--- logic/adcseq_top.sv
// adcseq_top: track/hold and conversion sequencer of a serial 8-bit converter.
// assumes a bus front end that flags a valid own address byte on the link clock.
// Operation
// - with the internal clock, tracking starts on the ninth falling bus clock edge of the address.
// - with the internal clock, hold follows two internal clock cycles after tracking began.
// - with the internal clock, each conversion takes eight cycles and the clock line is held low.
// - with the external clock, tracking starts on the seventh falling edge of a valid address.
// - with the external clock, hold starts on the eighth falling edge of the address.
// - with the external clock, conversion uses the next eight bus clocks the master supplies.
// - single-ended inputs route the chosen channel against ground.
// - pseudo-differential inputs route the pair's positive input against its negative input.
// - one result bit is decided per conversion clock, giving an eight-bit code.
// - the reference selection sets the shared pin as input, reference input or output.
// - with the external clock, conversion steps advance only on bus clock cycles.
// - a reference selection with both upper bits set drives the internal reference out.
// - a bus byte takes nine clock cycles, eight data plus acknowledge.
`default_nettype none
module adcseq_top
   import adcseq_pkg::*;
(
   // clocks and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic scl_clk_in,
   // link side, on the bus clock
   input wire logic addr_start_in,
   input wire logic addr_match_in,
   // configuration
   input wire logic [2:0] ref_sel_in,
   input wire logic ext_clk_in,
   input wire logic single_ended_in,
   input wire logic [3:0] chan_sel_in,
   input wire logic [3:0] conv_count_in,
   // analog front end
   input wire logic comp_in,
   output logic track_out,
   output logic [7:0] dac_out,
   output adcseq_mux_t mux_out,
   output adcseq_pin_role_t input3_or_reference_pin_out,
   // results and bus clock stretching
   output logic [7:0] result_out,
   output logic result_valid_out,
   output logic scl_out,
   output logic scl_oe_out,
   output logic busy_out
);
   // link domain: count falling edges within the address byte
   logic [3:0] edge_cnt_reg;
   logic in_addr_reg, lk_tgl_reg;
   logic [3:0] edge_cnt_next;
   assign edge_cnt_next = addr_start_in ? 4'h1 : edge_cnt_reg + 4'h1;
   always_ff @(negedge scl_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         edge_cnt_reg <= 4'h0;
         in_addr_reg <= 1'b0;
         lk_tgl_reg <= 1'b0;
      end else begin
         edge_cnt_reg <= edge_cnt_next;
         if (addr_start_in)
            in_addr_reg <= 1'b1;
         else if (edge_cnt_reg == ADCSEQ_BYTE_EDGES)
            in_addr_reg <= 1'b0;
         // each falling edge inside the byte becomes a toggle event
         lk_tgl_reg <= ~lk_tgl_reg;
      end
   end
   // three-stage crossing of the toggle; count and flags are read only once the toggle
   // agrees in two stages, so they have stood still for at least one clock by then
   logic [2:0] tgl_sync_reg;
   logic seen_reg;
   logic [3:0] cnt_s1_reg, cnt_s2_reg;
   logic addr_s1_reg, addr_s2_reg, addr_s3_reg, match_s1_reg, match_s2_reg, match_s3_reg;
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tgl_sync_reg <= 3'h0;
         seen_reg <= 1'b0;
         cnt_s1_reg <= 4'h0;
         cnt_s2_reg <= 4'h0;
         addr_s1_reg <= 1'b0;
         addr_s2_reg <= 1'b0;
         addr_s3_reg <= 1'b0;
         match_s1_reg <= 1'b0;
         match_s2_reg <= 1'b0;
         match_s3_reg <= 1'b0;
      end else begin
         tgl_sync_reg <= {tgl_sync_reg[1:0], lk_tgl_reg};
         seen_reg <= tgl_sync_reg[2];
         cnt_s1_reg <= edge_cnt_reg;
         cnt_s2_reg <= cnt_s1_reg;
         addr_s1_reg <= in_addr_reg;
         addr_s2_reg <= addr_s1_reg;
         addr_s3_reg <= addr_s2_reg;
         match_s1_reg <= addr_match_in;
         match_s2_reg <= match_s1_reg;
         match_s3_reg <= match_s2_reg;
      end
   end
   // an edge counts once the second and third stages agree on a new value
   logic fall_evt;
   logic ext_mode;
   logic addr_ok;
   logic match_ok;
   assign fall_evt = tgl_sync_reg[2] == tgl_sync_reg[1] && tgl_sync_reg[2] != seen_reg;
   assign ext_mode = ext_clk_in;
   assign addr_ok = addr_s2_reg && addr_s3_reg;
   assign match_ok = match_s2_reg && match_s3_reg;
   // edge 9 also needs the address window, else later bytes would restart tracking
   wire at_edge7 = fall_evt && addr_ok && cnt_s2_reg == ADCSEQ_TRACK_EDGE_EXT;
   wire at_edge8 = fall_evt && addr_ok && cnt_s2_reg == ADCSEQ_HOLD_EDGE_EXT;
   wire at_edge9 = fall_evt && addr_ok && cnt_s2_reg == ADCSEQ_TRACK_EDGE_INT;

   // internal conversion clock tick, one per eight system clocks; the divider restarts
   // as tracking begins, so acquisition is two whole ticks and never a partial one
   logic [2:0] div_reg, div_next;
   logic int_tick;
   assign int_tick = div_reg == 3'h7;
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         div_reg <= 3'h0;
      else
         div_reg <= div_next;
   end
   // step source: bus clock edges in external mode, internal ticks otherwise
   logic step_tick;
   assign step_tick = ext_mode ? fall_evt : int_tick;

   typedef enum logic [2:0] {S_IDLE, S_TRACK, S_CONV, S_DONE} adcseq_state_t;
   adcseq_state_t state_reg, state_next;
   logic [1:0] acq_reg, acq_next;
   logic [3:0] step_reg, step_next, left_reg, left_next;
   logic sar_start, sar_step, sar_done;
   // sequencer next-state decode
   always_comb begin
      state_next = state_reg;
      acq_next = acq_reg;
      step_next = step_reg;
      left_next = left_reg;
      sar_start = 1'b0;
      case (state_reg)
         S_IDLE: begin
            if (ext_mode && at_edge7 && match_ok) begin
               state_next = S_TRACK;
            end else if (!ext_mode && at_edge9 && match_ok) begin
               state_next = S_TRACK;
               acq_next = 2'h0;
               left_next = conv_count_in;
            end
         end
         S_TRACK: begin
            if (ext_mode && at_edge8) begin
               state_next = S_CONV;
               step_next = 4'h0;
               left_next = 4'h0;
               sar_start = 1'b1;
            end else if (!ext_mode && int_tick) begin
               acq_next = acq_reg + 2'h1;
               if (acq_reg + 2'h1 == ADCSEQ_ACQ_INT) begin
                  state_next = S_CONV;
                  step_next = 4'h0;
                  sar_start = 1'b1;
               end
            end
         end
         S_CONV: begin
            if (step_tick) begin
               step_next = step_reg + 4'h1;
               if (step_reg + 4'h1 == ADCSEQ_CONV_STEPS) begin
                  state_next = S_DONE;
               end
            end
         end
         S_DONE: begin
            // chain further internal conversions, else release the line
            if (!ext_mode && left_reg > 4'h1) begin
               left_next = left_reg - 4'h1;
               state_next = S_TRACK;
               acq_next = 2'h0;
            end else begin
               state_next = S_IDLE;
            end
         end
         default: state_next = S_IDLE;
      endcase
   end
   assign sar_step = state_reg == S_CONV && step_tick;
   // internal clock phase starts fresh with every track period
   logic track_begin;
   assign track_begin = state_next == S_TRACK && state_reg != S_TRACK;
   assign div_next = track_begin ? 3'h0 : div_reg + 3'h1;
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= S_IDLE;
         acq_reg <= 2'h0;
         step_reg <= 4'h0;
         left_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         acq_reg <= acq_next;
         step_reg <= step_next;
         left_reg <= left_next;
      end
   end

   adcseq_sar u_sar (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .start_in(sar_start),
      .step_in(sar_step),
      .comp_in(comp_in),
      .trial_out(dac_out),
      .result_out(result_out),
      .done_out(sar_done)
   );

   // routing and pin role, registered for clean analog control
   adcseq_mux_t mux_next;
   adcseq_pin_role_t role_next;
   assign mux_next.pos_sel = single_ended_in ? chan_sel_in : {chan_sel_in[3:1], 1'b0};
   assign mux_next.neg_sel = single_ended_in ? 4'h0 : {chan_sel_in[3:1], 1'b1};
   assign mux_next.neg_is_gnd = single_ended_in;
   assign role_next = ref_sel_in[2:1] == 2'h3 ? ADCSEQ_PIN_REF_OUT :
                      (ref_sel_in[2:1] == 2'h0 ? ADCSEQ_PIN_INPUT : ADCSEQ_PIN_REF_IN);
   logic track_reg, busy_reg, valid_reg, stretch_reg;
   adcseq_mux_t mux_reg;
   adcseq_pin_role_t role_reg;
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mux_reg <= '0;
         role_reg <= ADCSEQ_PIN_INPUT;
         track_reg <= 1'b0;
         busy_reg <= 1'b0;
         valid_reg <= 1'b0;
         stretch_reg <= 1'b0;
      end else begin
         mux_reg <= mux_next;
         role_reg <= role_next;
         track_reg <= state_next == S_TRACK;
         busy_reg <= state_next != S_IDLE;
         valid_reg <= sar_done;
         // clock line held low for the whole internal sequence
         stretch_reg <= !ext_mode && (state_next == S_TRACK || state_next == S_CONV
                        || (state_next == S_DONE));
      end
   end
   assign mux_out = mux_reg;
   assign input3_or_reference_pin_out = role_reg;
   assign track_out = track_reg;
   assign busy_out = busy_reg;
   assign result_valid_out = valid_reg;
   assign scl_out = 1'b0;
   assign scl_oe_out = stretch_reg;

   // checks
   property p_hold_after_two;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (state_reg == S_IDLE && !ext_mode && at_edge9 && match_ok)
         |-> ##[15:17] state_reg == S_CONV;
   endproperty
   a_hold_after_two: assert property (p_hold_after_two) else $error("hold not two ticks");
   property p_stretch;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (state_reg == S_CONV && !ext_mode) |-> scl_oe_out && !scl_out;
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock not held low");
   property p_release;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (state_reg == S_IDLE && $past(state_reg) == S_IDLE) |-> !scl_oe_out;
   endproperty
   a_release: assert property (p_release) else $error("clock line not released");
   property p_ref_out;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (ref_sel_in[2:1] == 2'h3) ##1 1'b1 |-> input3_or_reference_pin_out == ADCSEQ_PIN_REF_OUT;
   endproperty
   a_ref_out: assert property (p_ref_out) else $error("reference not driven out");
   property p_ext_track;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (state_reg == S_IDLE && ext_mode && at_edge7 && match_ok) |=> track_out;
   endproperty
   a_ext_track: assert property (p_ext_track) else $error("no track at seventh edge");
   property p_ext_hold;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (state_reg == S_TRACK && ext_mode && at_edge8) |=> !track_out;
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("no hold at eighth edge");
   property p_ext_step;
      @(posedge mclk_in) disable iff (!reset_n_in)
      (state_reg == S_CONV && ext_mode && !fall_evt) |=> $stable(step_reg);
   endproperty
   a_ext_step: assert property (p_ext_step) else $error("step without bus clock");
   property p_single;
      @(posedge mclk_in) disable iff (!reset_n_in)
      single_ended_in ##1 single_ended_in
         |-> mux_out.neg_is_gnd && mux_out.pos_sel == $past(chan_sel_in);
   endproperty
   a_single: assert property (p_single) else $error("single-ended routing wrong");
endmodule // adcseq_top
`default_nettype wire

//--- test/adcseq_bus_master.sv
// adcseq_bus_master: behavioural two-wire master that clocks address frames.
// assumes the bench resolves the clock wire from both parties and feeds it back.
`default_nettype none
module adcseq_bus_master (
   // control from the bench
   input wire logic go_in,
   input wire logic match_in,
   input wire logic [4:0] clocks_in,
   input wire logic scl_wire_in,
   // bus side
   output logic scl_drive_out,
   output logic addr_start_out,
   output logic addr_match_out,
   output logic busy_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // clock stands high between frames, where the pull-up leaves it
   initial begin
      scl_drive_out = 1'b1;
      addr_start_out = 1'b0;
      addr_match_out = 1'b0;
      busy_out = 1'b0;
      forever begin
         @(posedge go_in);
         busy_out = 1'b1;
         addr_match_out = match_in;
         addr_start_out = 1'b1;
         #3; // keeps bus clock edges off the system clock edges
         for (int i = 0; i < int'(clocks_in); i++) begin
            wait (scl_wire_in); // honours the device holding the clock low
            #24 scl_drive_out = 1'b0;
            #1 addr_start_out = 1'b0;
            #23 if (i < int'(clocks_in) - 1) scl_drive_out = 1'b1;
         end
         // low phase stretched so the device can seize the line first
         #24 scl_drive_out = 1'b1;
         wait (scl_wire_in);
         #24 addr_match_out = 1'b0;
         busy_out = 1'b0;
      end
   end
endmodule // adcseq_bus_master
`default_nettype wire

//--- test/adcseq_top_tb_top.sv
// adcseq_top_tb_top: self-checking bench of the track/hold sequencer.
// assumes a comparator model that keeps a trial code not above the input.
`default_nettype none
module adcseq_top_tb_top;
   import adcseq_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_in, reset_n_in, comp_in, ext_clk_in, single_ended_in, go, match, m_scl, m_busy;
   logic addr_start_in, addr_match_in, track_out, result_valid_out, scl_out, scl_oe_out, busy_out;
   logic trk_prev, oe_seen, bsy_seen;
   logic [2:0] ref_sel_in;
   logic [3:0] chan_sel_in, conv_count_in;
   logic [4:0] clocks;
   logic [7:0] dac_out, result_out, vin, edges, trk_on, trk_off, trk_len, pulses;
   adcseq_mux_t mux_out;
   adcseq_pin_role_t pin_role;
   int failures, comparisons, ticks;
   wire scl_wire = (scl_oe_out === 1'b1) ? scl_out : m_scl;
   adcseq_top i_adcseq_top (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .scl_clk_in(scl_wire),
      .addr_start_in(addr_start_in), .addr_match_in(addr_match_in), .ref_sel_in(ref_sel_in),
      .ext_clk_in(ext_clk_in), .single_ended_in(single_ended_in), .chan_sel_in(chan_sel_in),
      .conv_count_in(conv_count_in), .comp_in(comp_in), .track_out(track_out),
      .dac_out(dac_out), .mux_out(mux_out), .input3_or_reference_pin_out(pin_role),
      .result_out(result_out), .result_valid_out(result_valid_out), .scl_out(scl_out),
      .scl_oe_out(scl_oe_out), .busy_out(busy_out));
   adcseq_bus_master i_adcseq_bus_master (.go_in(go), .match_in(match), .clocks_in(clocks),
      .scl_wire_in(scl_wire), .scl_drive_out(m_scl), .addr_start_out(addr_start_in),
      .addr_match_out(addr_match_in), .busy_out(m_busy));
   initial begin
      mclk_in = 1'b0;
      forever #4 mclk_in = ~mclk_in;
   end
   // falling bus edges within a frame, as the device counts them
   always @(negedge scl_wire) if (m_busy) edges <= edges + 8'h01;
   // track window, result pulses, comparator model and hang guard
   always @(posedge mclk_in) begin
      if (track_out === 1'b1) trk_len <= trk_len + 8'h01;
      if (track_out === 1'b1 && !trk_prev) trk_on <= edges;
      if (track_out !== 1'b1 && trk_prev) trk_off <= edges;
      trk_prev <= (track_out === 1'b1);
      if (result_valid_out === 1'b1) pulses <= pulses + 8'h01;
      if (scl_oe_out === 1'b1) oe_seen <= 1'b1;
      if (busy_out === 1'b1) bsy_seen <= 1'b1;
      comp_in <= (dac_out <= vin);
      ticks++;
      if (ticks == 20000) begin
         failures++;
         close_out();
      end
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (exp !== got) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one address frame of n bus clocks; the settle wait covers the last conversion
   task automatic frame(input logic ext, input logic [4:0] n, input logic m, input logic [7:0] v);
      @(posedge mclk_in);
      ext_clk_in <= ext;
      clocks <= n;
      match <= m;
      vin <= v;
      {edges, trk_on, trk_off, trk_len, pulses, oe_seen, bsy_seen} <= '0;
      repeat (2) @(posedge mclk_in);
      go <= 1'b1;
      @(posedge mclk_in);
      go <= 1'b0;
      repeat (4) @(posedge mclk_in);
      while (m_busy === 1'b1) @(posedge mclk_in);
      repeat (20) @(posedge mclk_in);
   endtask
   function automatic logic [1:0] role_exp(input logic [2:0] r);
      if (r[2:1] == 2'h3) return ADCSEQ_PIN_REF_OUT;
      if (r[2:1] == 2'h0) return ADCSEQ_PIN_INPUT;
      return ADCSEQ_PIN_REF_IN;
   endfunction
   initial begin
      {reset_n_in, comp_in, go, match, trk_prev, oe_seen, bsy_seen, ext_clk_in} = '0;
      {single_ended_in, ref_sel_in, chan_sel_in, conv_count_in, clocks} = '0;
      {vin, edges, trk_on, trk_off, trk_len, pulses} = '0;
      {failures, comparisons, ticks} = '0;
      repeat (20) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      // external clock, single-ended channel 5
      single_ended_in <= 1'b1;
      chan_sel_in <= 4'h5;
      frame(1'b1, 5'h11, 1'b1, 8'hA5);
      check("ext track edge", 8'h07, trk_on);
      check("ext hold edge", 8'h08, trk_off);
      check("ext track length", 8'h01, {7'h00, trk_len >= 8'h05 && trk_len <= 8'h07});
      check("ext pulses", 8'h01, pulses);
      check("ext result", 8'hA5, result_out);
      check("se pos", 8'h05, {4'h0, mux_out.pos_sel});
      check("se gnd", 8'h01, {7'h00, mux_out.neg_is_gnd});
      check("ext busy", 8'h01, {7'h00, bsy_seen});
      $display("test external done");
      // address not ours: nothing may start
      frame(1'b1, 5'h11, 1'b0, 8'h33);
      check("nomatch track", 8'h00, trk_len);
      check("nomatch pulses", 8'h00, pulses);
      check("nomatch busy", 8'h00, {7'h00, bsy_seen});
      $display("test foreign address done");
      // internal clock, two chained conversions, pseudo-differential pair 1
      single_ended_in <= 1'b0;
      chan_sel_in <= 4'h3;
      conv_count_in <= 4'h2;
      frame(1'b0, 5'h09, 1'b1, 8'h5A);
      check("int track edge", 8'h09, trk_on);
      // two chained conversions, each tracking two ticks of eight system clocks
      check("int track length", 8'h01, {7'h00, trk_len >= 8'h1F && trk_len <= 8'h21});
      check("int pulses", 8'h02, pulses);
      check("int stretch", 8'h01, {7'h00, oe_seen});
      check("int release", 8'h00, {7'h00, scl_oe_out});
      check("int idle", 8'h00, {7'h00, busy_out});
      check("int result", 8'h5A, result_out);
      check("pd pos", 8'h02, {4'h0, mux_out.pos_sel});
      check("pd neg", 8'h03, {4'h0, mux_out.neg_sel});
      check("pd gnd", 8'h00, {7'h00, mux_out.neg_is_gnd});
      $display("test internal done");
      // every reference selection against the shared pin role
      for (int r = 0; r < 8; r++) begin
         ref_sel_in <= 3'(r);
         repeat (6) @(posedge mclk_in);
         check("pin role", {6'h00, role_exp(3'(r))}, {6'h00, pin_role});
      end
      $display("test pin roles done");
      close_out();
   end
endmodule // adcseq_top_tb_top
`default_nettype wire
